// ==== dth_trip_handler.sv ====
// Purpose: Fault trip handler: latches the first trip, disables power, drives display.
// Assumes: Fault pins are asynchronous; configuration and commands come from logic on clk.
// Notes:   Trip codes follow a fixed priority; see the detection vector below.
// Function
// - Any detected trip disables the power output.
// - While tripped, lower line shows trip flag, upper line the trip code.
// - Displaced or removed servo option module raises trip 37.
// - Input 1 in 4-20 mA loss mode below 3 mA raises trip 27.
// - Input 2 in loop mode with loss trip raises trip 28 on loss.
// - Input 3 in loop mode with loss trip raises trip 29 on loss.
// - Largest frame only: module count changing to n raises trip 150 plus n.
// - Module count trip clears at power-up only if parameters were saved.
// - Parameter memory fault losing values raises trip 31.
// - Memory trip resets only after defaults loaded then saved.
// - Encoder supply overload beyond 300 mA raises trip 10.
// - Missing U commutation or no rotation raises trip 11.
// - Missing V commutation raises trip 12.
// - Missing W commutation raises trip 13.
// - Wrongly ordered U V W commutation raises trip 14.
// - Missing encoder A channel raises trip 15.
// - Missing encoder B channel raises trip 16.
// - Swapped A/B or sine/cosine, or reversed phases, raises trip 17.
`timescale 1ns/1ps
module dth_trip_handler #(
    parameter int  MOD_COUNT_W = dth_pkg::MOD_W,
    parameter bit  LARGE_FRAME = 1'b1
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire dth_pkg::dth_enc_fault_t      enc_fault_pin,
    input  wire logic                         option_module_absent_pin,
    input  wire logic                         param_memory_fault_pin,
    input  wire dth_pkg::dth_analog_in_t      analog_in1,
    input  wire dth_pkg::dth_analog_in_t      analog_in2,
    input  wire dth_pkg::dth_analog_in_t      analog_in3,
    input  wire logic [MOD_COUNT_W-1:0]       module_count,
    input  wire logic                         power_up_done,
    input  wire logic                         defaults_loaded,
    input  wire logic                         params_saved,
    input  wire logic                         trip_reset_req,
    output logic                              power_enable,
    output dth_pkg::dth_display_t             display,
    output logic                              option_module_displaced_trip,
    output logic                              current_loss_input1_trip,
    output logic                              current_loss_input2_trip,
    output logic                              current_loss_input3_trip,
    output logic                              module_count_changed_trip,
    output logic                              param_memory_fault_trip,
    output logic                              feedback_supply_overload_trip,
    output logic                              u_commutation_missing_trip,
    output logic                              v_commutation_missing_trip,
    output logic                              w_commutation_missing_trip,
    output logic                              commutation_order_wrong_trip,
    output logic                              channel_a_missing_trip,
    output logic                              channel_b_missing_trip,
    output logic                              quadrature_swapped_trip
);
    localparam int N = dth_pkg::NSRC;

    // Pins that come from outside the clock domain, in priority order.
    logic [N-1:0] pin_raw;
    logic [N-1:0] pin_sync;
    logic [N-1:0] detect;

    // Trip handler state.
    typedef enum logic [1:0] {
        DTH_RUN     = 2'b00,
        DTH_TRIPPED = 2'b01
    } dth_state_t;

    dth_state_t              state_reg;
    dth_state_t              state_next;
    logic [7:0]              code_reg;
    logic [7:0]              code_next;
    logic [MOD_COUNT_W-1:0]  mods_known_reg;
    logic [MOD_COUNT_W-1:0]  mods_known_next;
    logic                    mods_valid_reg;
    logic                    mods_valid_next;
    logic                    saved_since_reg;
    logic                    saved_since_next;
    logic                    defaults_seen_reg;
    logic                    defaults_seen_next;
    logic [N-1:0]            flags_reg;
    logic [N-1:0]            flags_next;

    // Every index takes a synchroniser, tie-offs included; index 0 is the highest priority.
    assign pin_raw = {4'h0,
                      option_module_absent_pin,
                      enc_fault_pin.quad_swapped,
                      enc_fault_pin.b_missing,
                      enc_fault_pin.a_missing,
                      enc_fault_pin.order_wrong,
                      enc_fault_pin.w_missing,
                      enc_fault_pin.v_missing,
                      enc_fault_pin.u_missing,
                      enc_fault_pin.supply_overload,
                      param_memory_fault_pin,
                      1'b0};

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : g_sync
            dth_sync u_sync (
                .clk   (clk),
                .rst   (rst),
                .pin   (pin_raw[g]),
                .level (pin_sync[g])
            );
        end
    endgenerate

    // Analog loss checks compare the loop current with the loss level.
    logic loss1;
    logic loss2;
    logic loss3;
    logic count_change;
    assign loss1 = analog_in1.loop_mode && analog_in1.trip_on_loss
                   && (analog_in1.current_ua < 16'(dth_pkg::LOSS_LEVEL_UA));
    assign loss2 = analog_in2.loop_mode && analog_in2.trip_on_loss
                   && (analog_in2.current_ua < 16'(dth_pkg::LOSS_LEVEL_UA));
    assign loss3 = analog_in3.loop_mode && analog_in3.trip_on_loss
                   && (analog_in3.current_ua < 16'(dth_pkg::LOSS_LEVEL_UA));
    assign count_change = LARGE_FRAME && mods_valid_reg
                          && (module_count != mods_known_reg);

    // Detection vector: index 0 has the highest priority.
    // Memory loss ranks second, after the module count change, because every other setting is suspect after it.
    always_comb
    begin
        detect     = pin_sync;
        detect[0]  = count_change;
        detect[11] = loss1;
        detect[12] = loss2;
        detect[13] = loss3;
        detect[14] = 1'b0;
    end

    // Fixed priority encoder from source index to trip code.
    function automatic logic [7:0] code_of(input int idx, input logic [MOD_COUNT_W-1:0] n);
        logic [7:0] c;
        c = dth_pkg::CODE_NONE;
        unique case (idx)
            0:       c = dth_pkg::CODE_MODULE_COUNT + 8'(n);
            1:       c = dth_pkg::CODE_PARAM_MEMORY;
            2:       c = dth_pkg::CODE_SUPPLY_OVERLOAD;
            3:       c = dth_pkg::CODE_U_MISSING;
            4:       c = dth_pkg::CODE_V_MISSING;
            5:       c = dth_pkg::CODE_W_MISSING;
            6:       c = dth_pkg::CODE_COMM_ORDER;
            7:       c = dth_pkg::CODE_A_MISSING;
            8:       c = dth_pkg::CODE_B_MISSING;
            9:       c = dth_pkg::CODE_QUAD_SWAPPED;
            10:      c = dth_pkg::CODE_MODULE_DISPLACED;
            11:      c = dth_pkg::CODE_LOSS_IN1;
            12:      c = dth_pkg::CODE_LOSS_IN2;
            13:      c = dth_pkg::CODE_LOSS_IN3;
            default: c = dth_pkg::CODE_NONE;
        endcase
        return c;
    endfunction

    logic       any_detect;
    logic [7:0] new_code;
    logic       reset_ok;

    // Lowest index wins when several sources fire together.
    always_comb
    begin
        new_code = dth_pkg::CODE_NONE;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (detect[i])
            begin
                new_code = code_of(i, module_count);
            end
        end
    end
    assign any_detect = |detect;

    // A reset request is honoured only as the active trip allows.
    always_comb
    begin
        if (flags_reg[1])
        begin
            reset_ok = trip_reset_req && defaults_seen_reg && params_saved;
        end
        else if (flags_reg[0])
        begin
            reset_ok = power_up_done && saved_since_reg;
        end
        else
        begin
            reset_ok = trip_reset_req;
        end
    end

    // Next-state logic for the trip latch and the reset bookkeeping.
    always_comb
    begin
        state_next         = state_reg;
        code_next          = code_reg;
        flags_next         = flags_reg;
        mods_known_next    = mods_known_reg;
        mods_valid_next    = 1'b1;
        saved_since_next   = saved_since_reg;
        defaults_seen_next = defaults_seen_reg || defaults_loaded;
        if (!mods_valid_reg)
        begin
            mods_known_next = module_count;
        end
        unique case (state_reg)
            DTH_RUN:
            begin
                if (any_detect)
                begin
                    state_next         = DTH_TRIPPED;
                    code_next          = new_code;
                    flags_next         = detect;
                    saved_since_next   = 1'b0;
                    defaults_seen_next = 1'b0;
                end
            end
            DTH_TRIPPED:
            begin
                if (params_saved)
                begin
                    saved_since_next = 1'b1;
                end
                // A pending module count change is the new count once saved.
                if (flags_reg[0] && params_saved)
                begin
                    mods_known_next = module_count;
                end
                if (reset_ok && !(any_detect && !flags_reg[0]))
                begin
                    state_next         = DTH_RUN;
                    code_next          = dth_pkg::CODE_NONE;
                    flags_next         = '0;
                    defaults_seen_next = 1'b0;
                end
            end
            default:
            begin
                state_next = DTH_TRIPPED;
                code_next  = dth_pkg::CODE_NONE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg         <= DTH_RUN;
            code_reg          <= dth_pkg::CODE_NONE;
            flags_reg         <= '0;
            mods_known_reg    <= '0;
            mods_valid_reg    <= 1'b0;
            saved_since_reg   <= 1'b0;
            defaults_seen_reg <= 1'b0;
        end
        else
        begin
            state_reg         <= state_next;
            code_reg          <= code_next;
            flags_reg         <= flags_next;
            mods_known_reg    <= mods_known_next;
            mods_valid_reg    <= mods_valid_next;
            saved_since_reg   <= saved_since_next;
            defaults_seen_reg <= defaults_seen_next;
        end
    end

    // Outputs come straight from the latched state.
    assign power_enable      = (state_reg == DTH_RUN);
    assign display.trip_flag = (state_reg == DTH_TRIPPED);
    assign display.trip_code = code_reg;

    assign module_count_changed_trip     = flags_reg[0];
    assign param_memory_fault_trip       = flags_reg[1];
    assign feedback_supply_overload_trip = flags_reg[2];
    assign u_commutation_missing_trip    = flags_reg[3];
    assign v_commutation_missing_trip    = flags_reg[4];
    assign w_commutation_missing_trip    = flags_reg[5];
    assign commutation_order_wrong_trip  = flags_reg[6];
    assign channel_a_missing_trip        = flags_reg[7];
    assign channel_b_missing_trip        = flags_reg[8];
    assign quadrature_swapped_trip       = flags_reg[9];
    assign option_module_displaced_trip  = flags_reg[10];
    assign current_loss_input1_trip      = flags_reg[11];
    assign current_loss_input2_trip      = flags_reg[12];
    assign current_loss_input3_trip      = flags_reg[13];
endmodule

// ==== dth_pkg.sv ====
// Purpose: Shared constants and carrier types for the drive trip handler.
// Assumes: One 250 MHz clock, asynchronous active-high reset.
// Notes:   Trip codes are the numbers shown on the upper display line.
package dth_pkg;

    localparam int CODE_W = 8;

    // Trip codes shown on the display.
    localparam logic [7:0] CODE_NONE             = 8'h00;
    localparam logic [7:0] CODE_SUPPLY_OVERLOAD  = 8'h0a; // 10
    localparam logic [7:0] CODE_U_MISSING        = 8'h0b; // 11
    localparam logic [7:0] CODE_V_MISSING        = 8'h0c; // 12
    localparam logic [7:0] CODE_W_MISSING        = 8'h0d; // 13
    localparam logic [7:0] CODE_COMM_ORDER       = 8'h0e; // 14
    localparam logic [7:0] CODE_A_MISSING        = 8'h0f; // 15
    localparam logic [7:0] CODE_B_MISSING        = 8'h10; // 16
    localparam logic [7:0] CODE_QUAD_SWAPPED     = 8'h11; // 17
    localparam logic [7:0] CODE_LOSS_IN1         = 8'h1b; // 27
    localparam logic [7:0] CODE_LOSS_IN2         = 8'h1c; // 28
    localparam logic [7:0] CODE_LOSS_IN3         = 8'h1d; // 29
    localparam logic [7:0] CODE_PARAM_MEMORY     = 8'h1f; // 31
    localparam logic [7:0] CODE_MODULE_DISPLACED = 8'h25; // 37
    localparam logic [7:0] CODE_MODULE_COUNT     = 8'h96; // 150, plus module count

    // Analog loss trip threshold, in microamps, and supply limit, in milliamps.
    localparam int LOSS_LEVEL_UA       = 3000;
    localparam int SUPPLY_LIMIT_MA     = 300;
    localparam int CUR_W               = 16;
    localparam int MOD_W               = 4;
    localparam logic [3:0] MOD_MAX     = 4'h8;

    // Width of the trip source vector: 14 trip sources and one spare index.
    localparam int NSRC = 15;

    // Reset value of the detector synchronisers.
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // Encoder and commutation fault indications from the feedback interface.
    typedef struct packed {
        logic supply_overload;
        logic u_missing;
        logic v_missing;
        logic w_missing;
        logic order_wrong;
        logic a_missing;
        logic b_missing;
        logic quad_swapped;
    } dth_enc_fault_t;

    // Configuration of one analog input.
    typedef struct packed {
        logic             loop_mode;
        logic             trip_on_loss;
        logic [CUR_W-1:0] current_ua;
    } dth_analog_in_t;

    // Display drive.
    typedef struct packed {
        logic              trip_flag;
        logic [CODE_W-1:0] trip_code;
    } dth_display_t;

endpackage

// ==== dth_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: The input is asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module dth_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       level_reg;
    logic       level_next;

    // A change counts only once stages two and three agree.
    always_comb
    begin
        sync_next  = {sync_reg[1:0], pin};
        level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_reg  <= dth_pkg::SYNC_RESET;
            level_reg <= 1'b0;
        end
        else
        begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

// ==== dth_trip_checker.sv ====
// Purpose: Concurrent checks on the trip handler ports.
// Assumes: One clock domain with an active-high asynchronous reset.
// Notes:   Bound to every instance of the trip handler.
`timescale 1ns/1ps
module dth_trip_checker #(
    parameter int MOD_COUNT_W = dth_pkg::MOD_W
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire dth_pkg::dth_enc_fault_t enc_fault_pin,
    input wire dth_pkg::dth_analog_in_t analog_in1,
    input wire logic [MOD_COUNT_W-1:0]  module_count,
    input wire logic                    trip_reset_req,
    input wire logic                    power_enable,
    input wire dth_pkg::dth_display_t   display,
    input wire logic                    option_module_displaced_trip,
    input wire logic                    current_loss_input1_trip,
    input wire logic                    module_count_changed_trip,
    input wire logic                    param_memory_fault_trip,
    input wire logic                    feedback_supply_overload_trip,
    input wire logic                    u_commutation_missing_trip
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic hi_pri;
    // Trips that outrank every encoder trip, so encoder codes are checked only without them.
    assign hi_pri = module_count_changed_trip | param_memory_fault_trip;
    property p_trip_off;
        display.trip_flag |-> !power_enable && display.trip_code != dth_pkg::CODE_NONE;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("power on or no code while tripped");
    property p_held;
        display.trip_flag && !module_count_changed_trip && !trip_reset_req
            |=> display.trip_flag && $stable(display.trip_code);
    endproperty
    a_held: assert property (p_held) else $error("trip let go without a reset");
    property p_pin;
        (power_enable && (|enc_fault_pin) && $stable(enc_fault_pin)) [*4] |=> !power_enable;
    endproperty
    a_pin: assert property (p_pin) else $error("encoder fault did not trip");
    property p_loss1;
        power_enable && analog_in1.loop_mode && analog_in1.trip_on_loss
            && analog_in1.current_ua < 16'(dth_pkg::LOSS_LEVEL_UA)
            |=> !power_enable && current_loss_input1_trip;
    endproperty
    a_loss1: assert property (p_loss1) else $error("loop loss on input one missed");
    property p_prio_u;
        $rose(display.trip_flag) && u_commutation_missing_trip && !hi_pri
            && !feedback_supply_overload_trip |-> display.trip_code == dth_pkg::CODE_U_MISSING;
    endproperty
    a_prio_u: assert property (p_prio_u) else $error("wrong code for missing U");
    property p_displaced;
        $rose(display.trip_flag) && display.trip_code == dth_pkg::CODE_MODULE_DISPLACED
            |-> option_module_displaced_trip;
    endproperty
    a_displaced: assert property (p_displaced) else $error("module code without cause");
    property p_mem;
        $rose(display.trip_flag) && param_memory_fault_trip && !module_count_changed_trip
            |-> display.trip_code == dth_pkg::CODE_PARAM_MEMORY;
    endproperty
    a_mem: assert property (p_mem) else $error("wrong code for memory fault");
    property p_count;
        $rose(display.trip_flag) && module_count_changed_trip
            |-> display.trip_code == dth_pkg::CODE_MODULE_COUNT + 8'($past(module_count));
    endproperty
    a_count: assert property (p_count) else $error("wrong module count code");
    c_restore: cover property ($rose(power_enable));
    c_count: cover property ($rose(display.trip_flag) && module_count_changed_trip);
    c_mem_over_supply: cover property (param_memory_fault_trip && feedback_supply_overload_trip);
endmodule

bind dth_trip_handler dth_trip_checker #(.MOD_COUNT_W(MOD_COUNT_W)) u_chk (
    .clk(clk), .rst(rst), .enc_fault_pin(enc_fault_pin), .analog_in1(analog_in1),
    .module_count(module_count), .trip_reset_req(trip_reset_req),
    .power_enable(power_enable), .display(display),
    .option_module_displaced_trip(option_module_displaced_trip),
    .current_loss_input1_trip(current_loss_input1_trip),
    .module_count_changed_trip(module_count_changed_trip),
    .param_memory_fault_trip(param_memory_fault_trip),
    .feedback_supply_overload_trip(feedback_supply_overload_trip),
    .u_commutation_missing_trip(u_commutation_missing_trip)
);

// ==== dth_fault_source.sv ====
// Purpose: Behavioural far side: encoder pins, option module, memory and analog loops.
// Assumes: The mask changes just after a rising clock edge.
// Notes:   Mask bits 0-7 encoder faults, 8 option module, 9-11 loop loss, 12 memory.
`timescale 1ns/1ps
module dth_fault_source (
    input  wire logic [12:0]        fault_mask,
    input  wire logic               loss_cfg,
    input  wire logic               at_limit,
    input  wire logic [15:0]        noise,
    output dth_pkg::dth_enc_fault_t enc_fault_pin,
    output logic                    option_module_absent_pin,
    output logic                    param_memory_fault_pin,
    output dth_pkg::dth_analog_in_t analog_in1,
    output dth_pkg::dth_analog_in_t analog_in2,
    output dth_pkg::dth_analog_in_t analog_in3
);
    logic [15:0] ok_ua;
    logic [15:0] low_ua;
    // Healthy loops wander above the loss level; at_limit parks them on its exact edge.
    always_comb
    begin
        ok_ua = at_limit ? 16'h0bb8 : 16'h0bb8 + {2'h0, noise[13:0]};
        low_ua = at_limit ? 16'h0bb7 : {5'h00, noise[10:0]};
        enc_fault_pin = dth_pkg::dth_enc_fault_t'({fault_mask[0], fault_mask[1], fault_mask[2],
            fault_mask[3], fault_mask[4], fault_mask[5], fault_mask[6], fault_mask[7]});
        option_module_absent_pin = fault_mask[8];
        param_memory_fault_pin = fault_mask[12];
        analog_in1 = {1'b1, loss_cfg, fault_mask[9] ? low_ua : ok_ua};
        analog_in2 = {1'b1, loss_cfg, fault_mask[10] ? low_ua : ok_ua};
        analog_in3 = {1'b1, loss_cfg, fault_mask[11] ? low_ua : ok_ua};
    end
endmodule

// ==== drive_trip_handler_test.sv ====
// Purpose: Self-checking bench for the drive trip handler.
// Assumes: 250 MHz clock; the fault source model plays the far side.
// Notes:   Expected trip codes wait in a queue until the monitor sees a trip.
`timescale 1ns/1ps
module drive_trip_handler_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] fault_mask = 13'h0000;
    logic loss_cfg = 1'b1;
    logic at_limit = 1'b0;
    logic [15:0] noise = 16'h0000;
    logic [31:0] rng = 32'hefdd;
    logic [3:0] module_count = 4'h4;
    logic [3:0] cmd = 4'h0;
    logic power_enable;
    logic flag_seen = 1'b0;
    dth_pkg::dth_display_t display;
    dth_pkg::dth_enc_fault_t enc_fault_pin;
    logic option_module_absent_pin;
    logic param_memory_fault_pin;
    dth_pkg::dth_analog_in_t analog_in1;
    dth_pkg::dth_analog_in_t analog_in2;
    dth_pkg::dth_analog_in_t analog_in3;
    logic [7:0] exp_q[$];
    logic [13:0] trips;
    int num_errors = 0;
    int checked = 0;

    dth_fault_source u_src (.fault_mask(fault_mask), .loss_cfg(loss_cfg), .at_limit(at_limit),
        .noise(noise), .enc_fault_pin(enc_fault_pin), .param_memory_fault_pin(param_memory_fault_pin),
        .option_module_absent_pin(option_module_absent_pin), .analog_in1(analog_in1),
        .analog_in2(analog_in2), .analog_in3(analog_in3));
    // Command bits are defaults loaded, saved, reset request and power-up, msb first.
    dth_trip_handler u_dut (.clk(clk), .rst(rst), .enc_fault_pin(enc_fault_pin),
        .option_module_absent_pin(option_module_absent_pin),
        .param_memory_fault_pin(param_memory_fault_pin), .analog_in1(analog_in1),
        .analog_in2(analog_in2), .analog_in3(analog_in3), .module_count(module_count),
        .power_up_done(cmd[0]), .defaults_loaded(cmd[3]), .params_saved(cmd[2]),
        .trip_reset_req(cmd[1]), .power_enable(power_enable), .display(display),
        .option_module_displaced_trip(trips[8]), .current_loss_input1_trip(trips[9]),
        .current_loss_input2_trip(trips[10]), .current_loss_input3_trip(trips[11]),
        .module_count_changed_trip(trips[13]), .param_memory_fault_trip(trips[12]),
        .feedback_supply_overload_trip(trips[0]), .u_commutation_missing_trip(trips[1]),
        .v_commutation_missing_trip(trips[2]), .w_commutation_missing_trip(trips[3]),
        .commutation_order_wrong_trip(trips[4]), .channel_a_missing_trip(trips[5]),
        .channel_b_missing_trip(trips[6]), .quadrature_swapped_trip(trips[7]));

    always #2 clk = ~clk;

    // Loop current jitter comes from an xorshift stream with a fixed start.
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    always @(posedge clk)
    begin
        rng = xorshift(rng);
        noise <= rng[15:0];
    end

    task automatic fail(input string msg);
        num_errors++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic end_sim;
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Sampled on the falling edge so the rising-edge updates have landed.
    always @(negedge clk)
    begin
        if (!rst && display.trip_flag === 1'b1 && !flag_seen)
        begin
            checked++;
            if (exp_q.size() == 0 || display.trip_code !== exp_q[0] || power_enable !== 1'b0) fail("wrong trip");
            // Every source that fired in the tripping cycle keeps its own flag.
            if (trips !== {exp_q.size() != 0 && exp_q[0] >= dth_pkg::CODE_MODULE_COUNT, fault_mask}) fail("wrong trip flags");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        flag_seen = (display.trip_flag === 1'b1);
    end

    task automatic wait_for(input logic want);
        for (int n = 0; n < 20 && display.trip_flag !== want; n++) @(negedge clk);
        checked++;
        if (display.trip_flag !== want)
        begin
            fail("wait ran out");
            end_sim();
        end
    endtask

    // Pins are released early enough that the synchronisers drain before any reset.
    task automatic raise(input logic [12:0] m, input logic [7:0] code);
        exp_q.push_back(code);
        @(posedge clk) fault_mask <= m;
        wait_for(1'b1);
        @(posedge clk) fault_mask <= 13'h0000;
        repeat (6) @(posedge clk);
    endtask

    task automatic strobe(input logic [3:0] v);
        @(posedge clk) cmd <= v;
        @(posedge clk) cmd <= 4'h0;
    endtask

    task automatic restored;
        wait_for(1'b0);
        checked++;
        if (power_enable !== 1'b1 || display !== 9'h000) fail("output not restored");
    endtask

    task automatic hold_state(input logic tripped);
        repeat (8) @(negedge clk);
        checked++;
        if (power_enable !== !tripped || display.trip_flag !== tripped) fail("trip state wrong");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 12; i++)
        begin
            raise(13'h0001 << i, i < 8 ? dth_pkg::CODE_SUPPLY_OVERLOAD + 8'(i) : i == 8 ? dth_pkg::CODE_MODULE_DISPLACED : dth_pkg::CODE_LOSS_IN1 + 8'(i - 9));
            strobe(4'h2);
            restored();
        end
        raise(13'h1000, dth_pkg::CODE_PARAM_MEMORY);
        strobe(4'h2);
        strobe(4'h6);
        hold_state(1'b1);
        strobe(4'h8);
        strobe(4'h6);
        restored();
        raise(13'h0022, dth_pkg::CODE_U_MISSING);
        strobe(4'h2);
        restored();
        raise(13'h1001, dth_pkg::CODE_PARAM_MEMORY);
        strobe(4'h8);
        strobe(4'h6);
        restored();
        @(posedge clk) loss_cfg <= 1'b0;
        @(posedge clk) fault_mask <= 13'h0200;
        hold_state(1'b0);
        @(posedge clk) fault_mask <= 13'h0000;
        loss_cfg <= 1'b1;
        at_limit <= 1'b1;
        hold_state(1'b0);
        raise(13'h0200, dth_pkg::CODE_LOSS_IN1);
        strobe(4'h2);
        restored();
        at_limit <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            exp_q.push_back(dth_pkg::CODE_MODULE_COUNT + (k == 0 ? 8'h05 : 8'h08));
            @(posedge clk) module_count <= k == 0 ? 4'h5 : 4'h8;
            wait_for(1'b1);
            strobe(4'h2);
            strobe(4'h1);
            hold_state(1'b1);
            strobe(4'h4);
            strobe(4'h1);
            restored();
        end
        checked++;
        if (exp_q.size() != 0) fail("expected trip never seen");
        end_sim();
    end
endmodule
